// File: key_matrix_unit.sv
`timescale 1ns/10ps
`include "key_matrix_map.svh"
// Notes on behaviour
// - four row outputs, eight column inputs, up to 16x8 with a decoder
// - scan row 0 upward, columns 0 to 7 within each row
// - with many keys pressed, only the lowest addresses are reported
// - encoder mode: columns 2..0 give the code, column 3 low flags a key
// - open-drain bit set makes row outputs open drain, else push-pull
// - pin-group bit picks which of two pin groups carries the keypad
// - scanning runs only while scan enable is set
// - array size field picks 4, 8 or 16 rows of eight columns
// - debounce counts equal scans; terminal count raises a key interrupt
// - row period is prescale times a 1.064 us tick (133 clocks)
// - three-key off, interrupt, or chip reset per enable and select
// - three-key match raises interrupt or pulls the reset output low
// - wakeup works only while wakeup enable is set
// - eight-bit mask selects which wakeup-row columns can wake
// - wakeup row is binary for 8/16 rows, one-hot for 4 rows
// - interrupt bit set on key change or three-key match, not on a three-key reset; read clears
// - reset record flag set after three-key reset, cleared on read
// - wakeup flag shows the keypad woke the chip
// - status flags show three-key match, two-or-more-key or one-key detection
module key_matrix_unit #(
   parameter int unsigned RESET_PULSE = `KMU_RESET_PULSE_CYCLES
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst,
   input  wire key_matrix_pkg::apb_req_t i_apb,
   output logic                 [31:0] o_prdata,
   output logic                        o_pready,
   output logic                        o_pslverr,
   input  wire logic             [7:0] i_column_sense_in,
   input  wire logic                   i_powerdown,
   output logic                  [3:0] o_row_scan_out,
   output logic                  [3:0] o_row_scan_oe_n,
   output logic                        o_pin_group_select,
   output logic                        o_irq,
   output logic                        o_system_reset_out_n,
   output logic                        o_wakeup
);
   import key_matrix_pkg::*;

   generate
      if (RESET_PULSE < 1 || RESET_PULSE > 65535) begin : g_chk
         $error("key_matrix_unit: RESET_PULSE out of range");
      end
   endgenerate

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [3:0] last_row(input logic [1:0] size);
      case (size)
         2'b00:   last_row = 4'd3;
         2'b01:   last_row = 4'd7;
         default: last_row = 4'd15;
      endcase
   endfunction

   // four rows are driven directly one-hot low, larger arrays use a decoder
   function automatic logic [3:0] row_pattern(input logic [1:0] size,
                                              input logic [3:0] r);
      row_pattern = (size == 2'b00) ? ~(4'h1 << r[1:0]) : r;
   endfunction

   // ------------------------------------------------------------
   // registers and bus
   // ------------------------------------------------------------
   logic [31:0] keypad_config;
   logic [31:0] three_key_config;
   logic [31:0] low_power_wakeup_config;
   logic        rec_flag;
   logic        pdw_flag;
   logic        triple_match_flag;
   logic        double_press_flag;
   logic        single_press_flag;
   key_list_t   shown;
   logic        access;
   logic        mapped;
   logic        wr;
   logic        rd_status;
   logic [31:0] rd_word;

   wire       encode        = keypad_config[`KMU_ENCODE_BIT];
   wire       open_drain    = keypad_config[`KMU_OPEN_DRAIN_BIT];
   wire       scan_enable   = keypad_config[`KMU_SCAN_EN_BIT];
   wire [1:0] array_rows    = keypad_config[`KMU_SIZE_LSB +: 2];
   wire [7:0] debounce_terminal_count          = keypad_config[`KMU_DEBOUNCE_TERMINAL_COUNT_LSB +: 8];
   wire [7:0] prescale      = keypad_config[`KMU_PRESCALE_LSB +: 8];
   wire       triple_en     = three_key_config[`KMU_TRIPLE_EN_BIT];
   wire       triple_rst    = three_key_config[`KMU_TRIPLE_RST_BIT];
   wire       wake_en       = low_power_wakeup_config[`KMU_WAKE_EN_BIT];
   wire [7:0] wake_mask     = low_power_wakeup_config[`KMU_WAKE_COL_LSB +: 8];
   wire [3:0] wake_row      = low_power_wakeup_config[`KMU_WAKE_ROW_LSB +: 4];

   // one wait state: pready rises in the second access cycle
   assign access    = i_apb.psel & i_apb.penable & ~o_pready;
   assign wr        = access & i_apb.pwrite;
   assign mapped    = (i_apb.paddr == `KMU_CONF_ADDR)   ||
                      (i_apb.paddr == `KMU_TRIPLE_ADDR) ||
                      (i_apb.paddr == `KMU_WAKE_ADDR)   ||
                      (i_apb.paddr == `KMU_STATUS_ADDR);
   assign rd_status = access & ~i_apb.pwrite &
                      (i_apb.paddr == `KMU_STATUS_ADDR);

   always_comb begin
      case (i_apb.paddr)
         `KMU_CONF_ADDR:   rd_word = keypad_config;
         `KMU_TRIPLE_ADDR: rd_word = three_key_config;
         `KMU_WAKE_ADDR:   rd_word = low_power_wakeup_config;
         `KMU_STATUS_ADDR: rd_word = {10'h000, o_irq, rec_flag, pdw_flag,
                                      triple_match_flag, double_press_flag,
                                      single_press_flag,
                                      1'b0, shown.k1, 1'b0, shown.k0};
         default:          rd_word = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h00000000;
      end else begin
         o_pready  <= access;
         o_pslverr <= access & ~mapped;
         o_prdata  <= (access & ~i_apb.pwrite) ? rd_word : 32'h00000000;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         keypad_config           <= `KMU_CONF_RST;
         three_key_config        <= `KMU_TRIPLE_RST;
         low_power_wakeup_config <= `KMU_WAKE_RST;
      end else if (wr) begin
         if (i_apb.paddr == `KMU_CONF_ADDR)
            keypad_config <= i_apb.pwdata & `KMU_CONF_MASK;
         if (i_apb.paddr == `KMU_TRIPLE_ADDR)
            three_key_config <= i_apb.pwdata & `KMU_TRIPLE_MASK;
         if (i_apb.paddr == `KMU_WAKE_ADDR)
            low_power_wakeup_config <= i_apb.pwdata & `KMU_WAKE_MASK;
      end
   end

   // ------------------------------------------------------------
   // scanning
   // ------------------------------------------------------------
   scan_state_t state;
   logic [3:0]  row;
   key_list_t   acc;
   key_list_t   prev;
   key_list_t   next_acc;
   logic [7:0]  deb_cnt;
   logic [7:0]  next_deb;
   logic [7:0]  eff_debounce_terminal_count;
   logic [7:0]  pressed;
   logic        base_tick;
   logic        row_tick;
   logic        scan_end;
   logic        fire;
   logic        match;
   logic        reset_fire;
   logic [15:0] rst_cnt;

   key_column_sampler u_sampler (
      .i_clk             (i_clk),
      .i_rst             (i_rst),
      .i_column_sense_in (i_column_sense_in),
      .i_encode          (encode),
      .o_pressed         (pressed)
   );

   key_scan_timer u_timer (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_run       (state != S_IDLE),
      .i_prescale  (prescale),
      .o_base_tick (base_tick),
      .o_row_tick  (row_tick)
   );

   // append this row's keys in column order, keeping the lowest three
   always_comb begin
      next_acc = acc;
      for (int c = 0; c < 8; c++) begin
         if (pressed[c] && next_acc.count < 3'd4) begin
            case (next_acc.count)
               3'd0:    next_acc.k0 = {row, 3'(c)};
               3'd1:    next_acc.k1 = {row, 3'(c)};
               3'd2:    next_acc.k2 = {row, 3'(c)};
               default: next_acc.k2 = next_acc.k2;
            endcase
            next_acc.count = next_acc.count + 3'd1;
         end
      end
   end

   assign scan_end = (state == S_SCAN) && row_tick && scan_enable &&
                     !i_powerdown && (row >= last_row(array_rows));
   assign eff_debounce_terminal_count = (debounce_terminal_count == 8'h00) ? 8'h01 : debounce_terminal_count;
   assign next_deb = (next_acc != prev) ? 8'h00 :
                     (deb_cnt == 8'hff) ? deb_cnt : deb_cnt + 8'h01;
   assign fire     = scan_end && (next_deb == eff_debounce_terminal_count) &&
                     (next_acc != shown);
   assign match    = triple_en && (next_acc.count == 3'd3) &&
                     (next_acc.k0 == three_key_config[`KMU_KEY0_LSB +: 7]) &&
                     (next_acc.k1 == three_key_config[`KMU_KEY1_LSB +: 7]) &&
                     (next_acc.k2 == three_key_config[`KMU_KEY2_LSB +: 7]);
   assign reset_fire = fire && match && triple_rst;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state   <= S_IDLE;
         row     <= 4'h0;
         acc     <= '0;
         prev    <= '0;
         deb_cnt <= 8'h00;
      end else begin
         case (state)
            S_IDLE: begin
               row <= 4'h0;
               acc <= '0;
               if (i_powerdown && wake_en)
                  state <= S_WAKE;
               else if (scan_enable && !i_powerdown)
                  state <= S_SCAN;
            end
            S_SCAN: begin
               if (!scan_enable || i_powerdown) begin
                  state <= S_IDLE;
               end else if (row_tick) begin
                  if (row >= last_row(array_rows)) begin
                     row     <= 4'h0;
                     acc     <= '0;
                     prev    <= next_acc;
                     deb_cnt <= next_deb;
                  end else begin
                     row <= row + 4'h1;
                     acc <= next_acc;
                  end
               end
            end
            S_WAKE: begin
               if (!i_powerdown || !wake_en)
                  state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // report, interrupt and three-key reset
   // ------------------------------------------------------------
   wire int_set  = fire && !(match && triple_rst);
   wire wake_hit = (state == S_WAKE) && base_tick && i_powerdown &&
                   wake_en && |(pressed & wake_mask);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         shown             <= '0;
         triple_match_flag <= 1'b0;
         double_press_flag <= 1'b0;
         single_press_flag <= 1'b0;
      end else if (fire) begin
         shown             <= next_acc;
         triple_match_flag <= match;
         double_press_flag <= !match && (next_acc.count >= 3'd2);
         single_press_flag <= (next_acc.count == 3'd1);
      end
   end

   // a set in the same cycle as the clearing read wins
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_irq    <= 1'b0;
         rec_flag <= 1'b0;
         pdw_flag <= 1'b0;
      end else begin
         o_irq    <= int_set | (o_irq & ~rd_status);
         rec_flag <= reset_fire | (rec_flag & ~rd_status);
         pdw_flag <= wake_hit | (pdw_flag & ~rd_status);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rst_cnt              <= 16'h0000;
         o_system_reset_out_n <= 1'b1;
      end else begin
         if (reset_fire)
            rst_cnt <= 16'(RESET_PULSE);
         else if (rst_cnt != 16'h0000)
            rst_cnt <= rst_cnt - 16'h0001;
         o_system_reset_out_n <= !(reset_fire || rst_cnt > 16'h0001);
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   logic [3:0] next_row_out;

   always_comb begin
      case (state)
         S_SCAN:  next_row_out = row_pattern(array_rows, row);
         S_WAKE:  next_row_out = (array_rows == 2'b00) ? ~wake_row
                                                       : wake_row;
         default: next_row_out = 4'hf;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_row_scan_out     <= 4'hf;
         o_row_scan_oe_n    <= 4'h0;
         o_pin_group_select <= 1'b0;
         o_wakeup           <= 1'b0;
      end else begin
         o_row_scan_out     <= next_row_out;
         o_row_scan_oe_n    <= open_drain ? next_row_out : 4'h0;
         o_pin_group_select <= keypad_config[`KMU_PIN_GROUP_BIT];
         o_wakeup           <= wake_hit;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_scan_stop;
      (state == S_SCAN && !scan_enable) |=> (state == S_IDLE);
   endproperty
   a_scan_stop: assert property (p_scan_stop)
      else $error("scan kept running while disabled");

   property p_row_step;
      (state == S_SCAN && scan_enable && !i_powerdown && row_tick &&
       row < last_row(array_rows)) |=> (row == $past(row) + 4'h1);
   endproperty
   a_row_step: assert property (p_row_step)
      else $error("row did not advance by one");

   property p_row_limit;
      (state == S_SCAN && $stable(array_rows)) |->
         (row <= last_row(array_rows));
   endproperty
   a_row_limit: assert property (p_row_limit)
      else $error("row beyond selected array size");

   property p_fire_count;
      fire |-> (deb_cnt + 8'h01 == eff_debounce_terminal_count) && (next_acc == prev);
   endproperty
   a_fire_count: assert property (p_fire_count)
      else $error("report before debounce terminal count");

   property p_irq_set;
      int_set |=> o_irq ##1 (o_irq || $past(rd_status));
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("interrupt not raised on key change");

   property p_irq_clear;
      (rd_status && !int_set) |=> !o_irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("status read did not clear interrupt");

   property p_reset_out;
      reset_fire |=> (!o_system_reset_out_n && rec_flag && !$rose(o_irq));
   endproperty
   a_reset_out: assert property (p_reset_out)
      else $error("three-key reset not driven");

   property p_push_pull;
      !$past(open_drain) |-> (o_row_scan_oe_n == 4'h0);
   endproperty
   a_push_pull: assert property (p_push_pull)
      else $error("push-pull rows not fully driven");

   property p_wake_gate;
      o_wakeup |-> $past(wake_en) && $past(i_powerdown);
   endproperty
   a_wake_gate: assert property (p_wake_gate)
      else $error("wakeup while wakeup disabled");

   c_single: cover property (fire && next_acc.count == 3'd1);
   c_double: cover property (fire && next_acc.count == 3'd2);
   c_triple_rst: cover property (reset_fire);
   c_wake: cover property (o_wakeup);
endmodule

// File: key_matrix_map.svh
`ifndef KEY_MATRIX_MAP_SVH
`define KEY_MATRIX_MAP_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define KMU_CONF_ADDR      32'hfff88000
`define KMU_TRIPLE_ADDR    32'hfff88004
`define KMU_WAKE_ADDR      32'hfff88008
`define KMU_STATUS_ADDR    32'hfff8800c

// ------------------------------------------------------------
// reset values and writable bits
// ------------------------------------------------------------
`define KMU_CONF_RST       32'h00000000
`define KMU_TRIPLE_RST     32'h00000000
`define KMU_WAKE_RST       32'h00000000
`define KMU_CONF_MASK      32'h003fffff
`define KMU_TRIPLE_MASK    32'h037f7f7f
`define KMU_WAKE_MASK      32'h0001ff0f

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define KMU_ENCODE_BIT     21
`define KMU_OPEN_DRAIN_BIT 20
`define KMU_PIN_GROUP_BIT  19
`define KMU_SCAN_EN_BIT    18
`define KMU_SIZE_LSB       16
`define KMU_DEBOUNCE_TERMINAL_COUNT_LSB       8
`define KMU_PRESCALE_LSB   0
`define KMU_TRIPLE_EN_BIT  25
`define KMU_TRIPLE_RST_BIT 24
`define KMU_KEY0_LSB       0
`define KMU_KEY1_LSB       8
`define KMU_KEY2_LSB       16
`define KMU_WAKE_EN_BIT    16
`define KMU_WAKE_COL_LSB   8
`define KMU_WAKE_ROW_LSB   0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define KMU_CLK_PERIOD_NS  8
`define KMU_TICK_PERIOD_NS 1067
`define KMU_RESET_PULSE_CYCLES 16

`endif

// File: key_matrix_pkg.sv
package key_matrix_pkg;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [2:0] count;
      logic [6:0] k2;
      logic [6:0] k1;
      logic [6:0] k0;
   } key_list_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_SCAN = 3'b010,
      S_WAKE = 3'b100
   } scan_state_t;

endpackage

// File: key_column_sampler.sv
`timescale 1ns/10ps
module key_column_sampler (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic [7:0] i_column_sense_in,
   input  wire logic       i_encode,
   output logic      [7:0] o_pressed
);
   logic [7:0] sync1;
   logic [7:0] sync2;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sync1 <= 8'hff;
         sync2 <= 8'hff;
      end else begin
         sync1 <= i_column_sense_in;
         sync2 <= sync1;
      end
   end

   // columns are pulled up; a pressed key reads low
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pressed <= 8'h00;
      end else if (i_encode) begin
         o_pressed <= sync2[3] ? 8'h00 : (8'h01 << sync2[2:0]);
      end else begin
         o_pressed <= ~sync2;
      end
   end
endmodule

// File: key_scan_timer.sv
`timescale 1ns/10ps
`include "key_matrix_map.svh"
module key_scan_timer #(
   parameter int unsigned TICK_CYCLES =
      `KMU_TICK_PERIOD_NS / `KMU_CLK_PERIOD_NS
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_run,
   input  wire logic [7:0] i_prescale,
   output logic            o_base_tick,
   output logic            o_row_tick
);
   logic [7:0] base_cnt;
   logic [7:0] pre_cnt;
   logic [7:0] pre_last;

   generate
      if (TICK_CYCLES < 1 || TICK_CYCLES > 255) begin : g_chk
         $error("key_scan_timer: TICK_CYCLES out of range");
      end
   endgenerate

   // a prescale of zero behaves as one
   assign pre_last = (i_prescale == 8'h00) ? 8'h00 : i_prescale - 8'h01;

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run) begin
         base_cnt    <= 8'h00;
         o_base_tick <= 1'b0;
      end else if (base_cnt == 8'(TICK_CYCLES - 1)) begin
         base_cnt    <= 8'h00;
         o_base_tick <= 1'b1;
      end else begin
         base_cnt    <= base_cnt + 8'h01;
         o_base_tick <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || !i_run) begin
         pre_cnt    <= 8'h00;
         o_row_tick <= 1'b0;
      end else begin
         o_row_tick <= 1'b0;
         if (o_base_tick) begin
            if (pre_cnt >= pre_last) begin
               pre_cnt    <= 8'h00;
               o_row_tick <= 1'b1;
            end else begin
               pre_cnt <= pre_cnt + 8'h01;
            end
         end
      end
   end
endmodule

// File: key_matrix_model.sv
`timescale 1ns/10ps
module key_matrix_model (
   input  wire logic [3:0]   i_row,
   input  wire logic [3:0]   i_oe_n,
   input  wire logic         i_dec,
   input  wire logic         i_enc,
   input  wire logic [127:0] i_keys,
   output logic      [7:0]   o_col
);
   logic [3:0] lvl;
   logic [7:0] hit;
   // --------------------------------------------
   // key matrix with pull-ups on rows and columns
   // --------------------------------------------
   always_comb begin
      lvl = i_row | i_oe_n;
      hit = 8'h00;
      for (int r = 0; r < 16; r++) begin
         if (i_dec ? (lvl == r[3:0]) : (r < 4 && !lvl[r])) begin
            hit = hit | i_keys[r*8 +: 8];
         end
      end
      o_col = ~hit;
      if (i_enc) begin
         o_col = 8'hff;
         for (int c = 7; c >= 0; c--) begin
            if (hit[c]) begin
               o_col = {4'hf, 1'b0, c[2:0]};
            end
         end
      end
   end
endmodule

// File: key_matrix_unit_tb.sv
`timescale 1ns/10ps
`include "key_matrix_map.svh"
module key_matrix_unit_tb;
   import key_matrix_pkg::*;
   localparam logic [31:0]  cfg_a = `KMU_CONF_ADDR;
   localparam logic [31:0]  trk_a = `KMU_TRIPLE_ADDR;
   localparam logic [31:0]  wk_a  = `KMU_WAKE_ADDR;
   localparam logic [31:0]  st_a  = `KMU_STATUS_ADDR;
   localparam logic [127:0] three = (128'h1 << 11) | (128'h1 << 16) |
                                    (128'h1 << 38);
   logic [31:0]  masks [3] = '{`KMU_CONF_MASK, `KMU_TRIPLE_MASK,
                               `KMU_WAKE_MASK};
   logic         i_clk    = 1'b0;
   logic         i_rst    = 1'b1;
   logic         pd       = 1'b0;
   apb_req_t     i_apb    = '0;
   logic [127:0] keys     = '0;
   logic [31:0]  conf     = '0;
   logic [31:0]  prdata, v;
   logic [65:0]  n, notes [$];
   logic [3:0]   row, oe_n;
   logic [7:0]   col;
   logic         pready, pslverr, pgs, irq, rst_n, wake;
   int           failures = 0;
   int           checked  = 0;
   int           wakes    = 0;
   int           seed     = 32'h63fd6561;

   always #4 i_clk = ~i_clk;

   key_matrix_unit #(.RESET_PULSE(2)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
      .i_apb(i_apb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_column_sense_in(col), .i_powerdown(pd),
      .o_row_scan_out(row), .o_row_scan_oe_n(oe_n),
      .o_pin_group_select(pgs), .o_irq(irq),
      .o_system_reset_out_n(rst_n), .o_wakeup(wake));

   key_matrix_model u_keys (.i_row(row), .i_oe_n(oe_n),
      .i_dec(conf[17:16] != 2'b00), .i_enc(conf[21]), .i_keys(keys),
      .o_col(col));

   // ----------------------------------
   // comparison, verdict and bus cycles
   // ----------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, d,
                      input logic [32:0] exp, mask);
      @(negedge i_clk);
      i_apb = '{1'b1, 1'b0, wr, a, d};
      notes.push_back({mask, exp});
      @(negedge i_clk);
      i_apb.penable = 1'b1;
      for (int k = 0; k < 4; k++) begin
         @(posedge i_clk);
         if (pready)
            break;
      end
      @(negedge i_clk);
      i_apb = '0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [32:0] exp, mask);
      bus(1'b0, a, 32'h0, exp, mask);
   endtask

   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d, 33'h0, {1'b1, 32'h0});
      if (a == cfg_a)
         conf = d;
   endtask

   // row period fixes the wait: several whole scans of 16 rows
   task automatic settle(input logic [32:0] exp, mask);
      repeat (8000) @(negedge i_clk);
      check(irq, 1'b1);
      rd(st_a, exp, mask);
   endtask

   task automatic wait_for(input int which);
      int k;
      k = 0;
      while (k < 4000 && !(which != 0 ? wake : !rst_n)) begin
         @(posedge i_clk);
         k++;
      end
      check(k < 4000, 1'b1);
   endtask

   always @(posedge i_clk) begin
      if (wake)
         wakes++;
      if (pready && notes.size() > 0) begin
         n = notes.pop_front();
         check({pslverr, prdata} & n[65:33], n[32:0]);
      end
   end

   initial begin
      #(8 * 90000);
      check(33'h0, 33'h1);
      complete_run();
   end

   // ---------
   // scenarios
   // ---------
   initial begin
      int k;
      repeat (5) @(negedge i_clk);
      i_rst = 1'b0;
      for (int i = 0; i < 4; i++)
         rd(cfg_a + i * 4, 33'h0, '1);
      rd(st_a + 32'h4, {1'b1, 32'h0}, '1);
      for (int i = 0; i < 3; i++) begin
         v = $random(seed) & masks[i];
         wr(cfg_a + i * 4, v);
         rd(cfg_a + i * 4, {1'b0, v}, '1);
      end
      check(pgs, conf[19]);
      for (int i = 0; i < 4; i++)
         wr(cfg_a + i * 4, 32'h0);
      rd(st_a, 33'h0, '1);
      wr(cfg_a, 32'h0014_0101);
      keys[21] = 1'b1;
      settle(33'h21_0015, '1);
      check(oe_n, row);
      rd(st_a, 33'h0, 33'h20_0000);
      @(negedge i_clk);
      check(irq, 1'b0);
      wr(cfg_a, 32'h0005_0101);
      keys = three;
      settle(33'h22_100b, 33'h23_7f7f);
      check(oe_n, 4'h0);
      v = row;
      while (row == v[3:0])
         @(negedge i_clk);
      v = row;
      k = 0;
      while (row == v[3:0]) begin
         @(negedge i_clk);
         k++;
      end
      check(k, `KMU_TICK_PERIOD_NS / `KMU_CLK_PERIOD_NS);
      wr(trk_a, 32'h0226_100b);
      keys = '0;
      settle(33'h20_0000, 33'h27_0000);
      keys = three;
      settle(33'h24_0000, 33'h24_0000);
      wr(trk_a, 32'h0326_100b);
      keys = '0;
      settle(33'h20_0000, 33'h20_0000);
      keys = three;
      wait_for(0);
      k = 0;
      while (!rst_n && k < 50) begin
         @(posedge i_clk);
         k++;
      end
      check(k, 2);
      rd(st_a, 33'h10_0000, 33'h30_0000);
      rd(st_a, 33'h0, 33'h10_0000);
      wr(trk_a, 32'h0);
      wr(wk_a, 32'h0000_ff00);
      wr(cfg_a, 32'h0026_0101);
      keys = 128'h1 << 76;
      settle(33'h21_004c, 33'h23_7f7f);
      wr(cfg_a, 32'h0);
      repeat (10) @(negedge i_clk);
      check(row, 4'hf);
      wr(cfg_a, 32'h0004_0101);
      wr(wk_a, 32'h0000_2508);
      keys = 128'h1 << 26;
      pd = 1'b1;
      repeat (400) @(negedge i_clk);
      check(wakes, 0);
      keys = 128'h1 << 25;
      wr(wk_a, 32'h0001_2508);
      repeat (400) @(negedge i_clk);
      check(wakes, 0);
      keys = 128'h1 << 26;
      wait_for(1);
      rd(st_a, 33'h08_0000, 33'h08_0000);
      pd = 1'b0;
      complete_run();
   end
endmodule
